// ===== design/cam_top.sv
// Identifier mask registers, acceptance check and spare port pins
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`include "cam_consts.svh"
module cam_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire cam_pkg::cam_bus_type bus,
  output logic [7:0] rdata,
  // Received message from the protocol engine
  input wire logic rx_valid,
  input wire logic [31:0] rx_idr,
  input wire logic rx_ext,
  // Acceptance result
  output logic rx_accept,
  // CAN pins
  input wire logic can_tx_pin,
  input wire logic can_rx_pin,
  // General-purpose port pins 7..2
  input wire logic [5:0] gp_in,
  output logic [5:0] gp_out,
  output logic [5:0] gp_oe_n,
  output logic gp_pull_en,
  output logic gp_reduced_drive
);
  import cam_pkg::*;
  logic [7:0] mask_q [8];
  logic [7:0] code_q [8];
  logic [7:0] next_mask [8];
  logic [7:0] next_code [8];
  logic [7:0] pctl, next_pctl;
  logic [5:0] pdata, next_pdata;
  logic [5:0] pdir, next_pdir;
  logic [1:0] forg, next_forg;
  logic srst, next_srst;
  logic [7:0] next_rdata;
  logic [31:0] idr_q, next_idr;
  logic [2:0] hit_idx, next_hit_idx;
  logic next_accept;
  logic [5:0] next_gp_out, next_gp_oe_n;
  logic [5:0] gp_read;
  logic [63:0] code_flat, mask_flat;
  cam_result_type fres;

  // Flatten filter tables
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      code_flat[8*i +: 8] = code_q[i];
      mask_flat[8*i +: 8] = mask_q[i];
    end
  end

  cam_filter u_filter (
    .code(code_flat),
    .mask(mask_flat),
    .forg(cam_forg_type'(forg)),
    .idr(rx_idr),
    .ext_id(rx_ext),
    .result(fres)
  );

  // Register writes
  always_comb begin
    next_mask = mask_q;
    next_code = code_q;
    next_pctl = pctl;
    next_pdata = pdata;
    next_pdir = pdir;
    next_forg = forg;
    next_srst = srst;
    if (bus.wr) begin
      for (int i = 0; i < 8; i++) begin
        if (srst && bus.addr == `CAM_OFS_MASK0 + 9'(i) && i < 4) begin
          next_mask[i] = bus.wdata;
        end
        if (srst && bus.addr == `CAM_OFS_MASK4 + 9'(i - 4) && i >= 4) begin
          next_mask[i] = bus.wdata;
        end
        if (srst && bus.addr == `CAM_OFS_CODE0 + 9'(i) && i < 4) begin
          next_code[i] = bus.wdata;
        end
        if (srst && bus.addr == `CAM_OFS_CODE4 + 9'(i - 4) && i >= 4) begin
          next_code[i] = bus.wdata;
        end
      end
      case (bus.addr)
        `CAM_OFS_PCTL: next_pctl = {6'h00, bus.wdata[1:0]};
        `CAM_OFS_PDATA: next_pdata = bus.wdata[7:2];
        `CAM_OFS_PDIR: next_pdir = bus.wdata[7:2];
        `CAM_OFS_CTL0: next_srst = bus.wdata[`CAM_BIT_SRST];
        `CAM_OFS_FCTL: begin
          if (srst) begin
            next_forg = bus.wdata[`CAM_FORG_LSB +: 2];
          end
        end
        default: ;
      endcase
    end
  end

  // Port pin read source per direction bit
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      gp_read[i] = pdir[i] ? pdata[i] : gp_in[i];
    end
  end

  // Read mux, data in the cycle after the strobe
  always_comb begin
    next_rdata = 8'h00;
    if (bus.rd) begin
      for (int i = 0; i < 8; i++) begin
        if (bus.addr == `CAM_OFS_MASK0 + 9'(i) && i < 4) begin
          next_rdata = mask_q[i];
        end
        if (bus.addr == `CAM_OFS_MASK4 + 9'(i - 4) && i >= 4) begin
          next_rdata = mask_q[i];
        end
        if (bus.addr == `CAM_OFS_CODE0 + 9'(i) && i < 4) begin
          next_rdata = code_q[i];
        end
        if (bus.addr == `CAM_OFS_CODE4 + 9'(i - 4) && i >= 4) begin
          next_rdata = code_q[i];
        end
      end
      case (bus.addr)
        `CAM_OFS_PCTL: next_rdata = pctl;
        `CAM_OFS_PDATA: begin
          // Bits 1 and 0 always show the live CAN pins
          next_rdata = {gp_read, can_tx_pin, can_rx_pin};
        end
        `CAM_OFS_PDIR: next_rdata = {pdir, 2'b00};
        `CAM_OFS_CTL0: next_rdata = {7'h00, srst};
        `CAM_OFS_FCTL: next_rdata = {2'b00, forg, 1'b0, hit_idx};
        `CAM_OFS_IDR: next_rdata = idr_q[7:0];
        `CAM_OFS_ACC: next_rdata = {7'h00, rx_accept};
        default: ;
      endcase
    end
  end

  // Acceptance: only hits update the foreground copy
  always_comb begin
    next_idr = idr_q;
    next_hit_idx = hit_idx;
    next_accept = 1'b0;
    if (rx_valid && !srst && fres.hit) begin
      next_idr = rx_idr;
      next_hit_idx = fres.hit_idx;
      next_accept = 1'b1;
    end
  end

  // Pin drive: pins 7..2 only
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      next_gp_out[i] = pdata[i];
      next_gp_oe_n[i] = ~pdir[i];
    end
  end

  // State registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        mask_q[i] <= `CAM_RST_MASK;
        code_q[i] <= 8'h00;
      end
      pctl <= `CAM_RST_PCTL;
      pdata <= 6'h00;
      pdir <= 6'h00;
      forg <= 2'b00;
      srst <= `CAM_RST_SRST;
      rdata <= 8'h00;
      idr_q <= 32'h0000_0000;
      hit_idx <= 3'h0;
      rx_accept <= 1'b0;
      gp_out <= 6'h00;
      gp_oe_n <= 6'h3f;
      gp_pull_en <= 1'b0;
      gp_reduced_drive <= 1'b0;
    end else begin
      mask_q <= next_mask;
      code_q <= next_code;
      pctl <= next_pctl;
      pdata <= next_pdata;
      pdir <= next_pdir;
      forg <= next_forg;
      srst <= next_srst;
      rdata <= next_rdata;
      idr_q <= next_idr;
      hit_idx <= next_hit_idx;
      rx_accept <= next_accept;
      gp_out <= next_gp_out;
      gp_oe_n <= next_gp_oe_n;
      gp_pull_en <= next_pctl[`CAM_BIT_PULL];
      gp_reduced_drive <= next_pctl[`CAM_BIT_RDRV];
    end
  end

  // Assertions
  property p_mask_locked;
    @(posedge mclk) disable iff (rst)
    (bus.wr && !srst && bus.addr == `CAM_OFS_MASK1) |=> $stable(mask_q[1]);
  endproperty
  a_mask_locked: assert property (p_mask_locked)
    else $error("mask changed outside soft reset");

  property p_mask_write;
    @(posedge mclk) disable iff (rst)
    (bus.wr && srst && bus.addr == `CAM_OFS_MASK5)
      |=> mask_q[5] == $past(bus.wdata);
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("mask write lost in soft reset");

  property p_oe_dir;
    @(posedge mclk) disable iff (rst)
    bus.wr && bus.addr == `CAM_OFS_PDIR ##2 1
      |-> gp_oe_n == ~$past(bus.wdata[7:2], 2);
  endproperty
  a_oe_dir: assert property (p_oe_dir)
    else $error("output enable does not follow direction");

  property p_pull;
    @(posedge mclk) disable iff (rst)
    (bus.wr && bus.addr == `CAM_OFS_PCTL)
      |=> gp_pull_en == $past(bus.wdata[1])
      && gp_reduced_drive == $past(bus.wdata[0]);
  endproperty
  a_pull: assert property (p_pull)
    else $error("pull or drive setting wrong");

  property p_read_pin;
    @(posedge mclk) disable iff (rst)
    (bus.rd && bus.addr == `CAM_OFS_PDATA)
      |=> rdata[1:0] == $past({can_tx_pin, can_rx_pin});
  endproperty
  a_read_pin: assert property (p_read_pin)
    else $error("can pin read wrong");

  property p_read_gp;
    @(posedge mclk) disable iff (rst)
    (bus.rd && bus.addr == `CAM_OFS_PDATA && pdir[0])
      |=> rdata[2] == $past(pdata[0]);
  endproperty
  a_read_gp: assert property (p_read_gp)
    else $error("output pin read not from latch");

  property p_closed;
    @(posedge mclk) disable iff (rst)
    (forg == 2'b11) |=> !rx_accept;
  endproperty
  a_closed: assert property (p_closed)
    else $error("message accepted while closed");

  property p_reject;
    @(posedge mclk) disable iff (rst)
    (rx_valid && !fres.hit) |=> !rx_accept && $stable(idr_q);
  endproperty
  a_reject: assert property (p_reject)
    else $error("rejected message signalled");

  property p_exact;
    @(posedge mclk) disable iff (rst)
    (forg == 2'b10 && mask_q[0] == 8'h00 && code_q[0] != rx_idr[7:0])
      |-> !(fres.hit && fres.hit_idx == 3'd0);
  endproperty
  a_exact: assert property (p_exact)
    else $error("unmasked mismatch gave hit");

  property p_dontcare;
    @(posedge mclk) disable iff (rst)
    (forg == 2'b10 && mask_q[0] == 8'hff) |-> fres.hit && fres.hit_idx == 0;
  endproperty
  a_dontcare: assert property (p_dontcare)
    else $error("fully masked filter missed");

  c_accept: cover property (@(posedge mclk) rx_accept);
  c_mask_wr: cover property (@(posedge mclk) bus.wr && srst
    && bus.addr == `CAM_OFS_MASK7);
  c_pin_out: cover property (@(posedge mclk) gp_oe_n != 6'h3f);
endmodule // cam_top

// ===== design/cam_consts.svh
// Offsets, field positions and reset values of the mask and port block
`ifndef CAM_CONSTS_SVH
`define CAM_CONSTS_SVH
`define CAM_ADDR_W 9
`define CAM_OFS_MASK0 9'h114
`define CAM_OFS_MASK1 9'h115
`define CAM_OFS_MASK2 9'h116
`define CAM_OFS_MASK3 9'h117
`define CAM_OFS_MASK4 9'h11c
`define CAM_OFS_MASK5 9'h11d
`define CAM_OFS_MASK6 9'h11e
`define CAM_OFS_MASK7 9'h11f
`define CAM_OFS_CODE0 9'h110
`define CAM_OFS_CODE4 9'h118
`define CAM_OFS_FCTL 9'h108
`define CAM_OFS_PCTL 9'h13d
`define CAM_OFS_PDATA 9'h13e
`define CAM_OFS_PDIR 9'h13f
`define CAM_OFS_CTL0 9'h100
`define CAM_OFS_IDR 9'h140
`define CAM_OFS_ACC 9'h144
`define CAM_BIT_PULL 1
`define CAM_BIT_RDRV 0
`define CAM_BIT_SRST 0
`define CAM_FORG_LSB 4
`define CAM_GP_LSB 2
`define CAM_GP_W 6
`define CAM_RST_PCTL 8'h00
`define CAM_RST_PDATA 8'h00
`define CAM_RST_PDIR 8'h00
`define CAM_RST_MASK 8'hff
`define CAM_RST_SRST 1'b1
`endif

// ===== design/cam_pkg.sv
// Types shared by the mask and port block
package cam_pkg;
  typedef enum logic [1:0] {
    CAM_F32 = 2'b00,
    CAM_F16 = 2'b01,
    CAM_F8 = 2'b10,
    CAM_FCLOSED = 2'b11
  } cam_forg_type;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [8:0] addr;
    logic [7:0] wdata;
  } cam_bus_type;
  typedef struct packed {
    logic hit;
    logic [2:0] hit_idx;
  } cam_result_type;
endpackage

// ===== design/cam_filter.sv
// Acceptance compare of received identifier bytes against code and mask
`timescale 1ns/1ps
module cam_filter (
  // Filter settings
  input wire logic [63:0] code,
  input wire logic [63:0] mask,
  input wire cam_pkg::cam_forg_type forg,
  // Received identifier
  input wire logic [31:0] idr,
  input wire logic ext_id,
  // Result
  output cam_pkg::cam_result_type result
);
  import cam_pkg::*;
  logic [7:0] bmatch;
  logic [7:0] fhit;
  // Per-byte match on unmasked bits only
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_byte
      logic [7:0] idb;
      // Sixteen-bit filters all look at the first two identifier bytes
      assign idb = (forg == CAM_F16) ? idr[8*(g%2) +: 8]
        : idr[8*(g%4) +: 8];
      assign bmatch[g] = &((~(code[8*g +: 8] ^ idb))
        | mask[8*g +: 8]);
    end
  endgenerate
  // Filter hits by organisation, lowest filter reported
  always_comb begin
    fhit = 8'h00;
    case (forg)
      CAM_F32: begin
        fhit[0] = &bmatch[1:0] & (~ext_id | &bmatch[3:2]);
        fhit[1] = &bmatch[5:4] & (~ext_id | &bmatch[7:6]);
      end
      CAM_F16: begin
        fhit[0] = &bmatch[1:0];
        fhit[1] = &bmatch[3:2];
        fhit[2] = &bmatch[5:4];
        fhit[3] = &bmatch[7:6];
      end
      CAM_F8: fhit = bmatch;
      default: fhit = 8'h00; // Closed: nothing accepted
    endcase
    result.hit = |fhit;
    result.hit_idx = 3'd0;
    for (int i = 7; i >= 0; i--) begin
      if (fhit[i]) begin
        result.hit_idx = 3'(i);
      end
    end
  end
endmodule // cam_filter

// ===== test/cam_pin_model.sv
// Far-side model of the spare port pins and the CAN pin levels
`timescale 1ns/1ps
module cam_pin_model (
  // Clock
  input wire logic mclk,
  // Block side of the pins
  input wire logic [5:0] gp_out,
  input wire logic [5:0] gp_oe_n,
  input wire logic gp_pull_en,
  output logic [5:0] gp_in,
  output logic can_tx_pin,
  output logic can_rx_pin,
  // Bench control of the outside world
  input wire logic [5:0] ext_val,
  input wire logic ext_drv,
  input wire logic [1:0] can_lvl
);
  logic [5:0] flt = 6'h2a;
  // Undriven pins without pull wander every cycle
  always @(posedge mclk) begin
    flt <= ~flt;
  end
  // Pin level from the block driver, an outside driver, pull or float
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (!gp_oe_n[i]) gp_in[i] = gp_out[i];
      else if (ext_drv) gp_in[i] = ext_val[i];
      else if (gp_pull_en) gp_in[i] = 1'b1;
      else gp_in[i] = flt[i];
    end
  end
  // Transceiver levels as the bench sets them
  assign can_tx_pin = can_lvl[1];
  assign can_rx_pin = can_lvl[0];
endmodule // cam_pin_model

// ===== test/test_can_accept_mask_port_io.sv
// Testbench of the mask registers, acceptance check and port pins
`timescale 1ns/1ps
`include "cam_consts.svh"
module test_can_accept_mask_port_io;
  import cam_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  cam_bus_type bus = '0;
  logic [7:0] rdata;
  logic rx_valid = 1'b0;
  logic [31:0] rx_idr = '0;
  logic rx_ext = 1'b0;
  logic rx_accept, can_tx_pin, can_rx_pin, gp_pull_en, gp_reduced_drive;
  logic [5:0] gp_in, gp_out, gp_oe_n;
  logic [5:0] ext_val = 6'h15;
  logic ext_drv = 1'b1;
  logic [1:0] can_lvl = 2'b10;
  int n_mismatch = 0;
  int check_count = 0;
  integer seed = 32'h9a6e;
  logic [7:0] code [8];
  logic [7:0] mask [8];
  logic [7:0] rd_val;
  logic [7:0] last_id;
  logic [31:0] dv, id, base;
  logic [3:0] e;
  logic [2:0] hv;
  logic seen, ext;
  // Clock
  always #10 mclk = ~mclk;
  // Design and far side
  cam_top i_dut (.mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata),
    .rx_valid(rx_valid), .rx_idr(rx_idr), .rx_ext(rx_ext),
    .rx_accept(rx_accept), .can_tx_pin(can_tx_pin),
    .can_rx_pin(can_rx_pin), .gp_in(gp_in), .gp_out(gp_out),
    .gp_oe_n(gp_oe_n), .gp_pull_en(gp_pull_en),
    .gp_reduced_drive(gp_reduced_drive));
  cam_pin_model i_pins (.mclk(mclk), .gp_out(gp_out), .gp_oe_n(gp_oe_n),
    .gp_pull_en(gp_pull_en), .gp_in(gp_in), .can_tx_pin(can_tx_pin),
    .can_rx_pin(can_rx_pin), .ext_val(ext_val), .ext_drv(ext_drv),
    .can_lvl(can_lvl));
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One-cycle register write
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    bus <= '0;
  endtask
  // One-cycle register read, data taken in the following cycle
  task automatic rd(input logic [8:0] a);
    @(posedge mclk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk);
    bus <= '0;
    #1 rd_val = rdata;
  endtask
  task automatic rchk(input logic [8:0] a, input logic [31:0] x);
    rd(a);
    chk(rd_val, x);
  endtask
  // Present one received identifier and look at the accept pulse
  task automatic rx(input logic [31:0] i, input logic x, input logic [3:0] h);
    @(posedge mclk);
    rx_valid <= 1'b1;
    rx_idr <= i;
    rx_ext <= x;
    @(posedge mclk);
    rx_valid <= 1'b0;
    #1 chk(rx_accept, h[3]);
  endtask
  // Acceptance code register address of filter byte i
  function automatic logic [8:0] caddr(int i);
    return (i < 4) ? `CAM_OFS_CODE0 + 9'(i) : `CAM_OFS_CODE4 + 9'(i - 4);
  endfunction
  function automatic logic byte_ok(logic [7:0] b, logic [7:0] c,
    logic [7:0] m);
    return ((b ^ c) & ~m) == 8'h00;
  endfunction
  // Expected hit flag and lowest hitting filter
  function automatic logic [3:0] exp_hit(logic [1:0] md, logic [31:0] i,
    logic x);
    logic [3:0] r;
    logic h;
    int st, nb;
    r = 4'h0;
    st = 4 >> md;
    nb = (md == 2'b00 && x) ? 4 : ((md == 2'b10) ? 1 : 2);
    for (int k = (2 << md) - 1; k >= 0; k--) begin
      h = (md != 2'b11);
      for (int j = 0; j < nb; j++) begin
        h &= byte_ok(i[8 * ((md == 2'b10) ? k % 4 : j) +: 8],
          code[st * k + j], mask[st * k + j]);
      end
      if (h) r = {1'b1, 3'(k)};
    end
    return r;
  endfunction
  // Counts, verdict and end of run
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Guard against a hang
  initial begin
    #1_000_000;
    n_mismatch++;
    give_verdict();
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    #1 chk({gp_oe_n, gp_out, gp_pull_en, gp_reduced_drive}, 14'h3f00);
    rchk(`CAM_OFS_PCTL, 8'h00);
    rchk(`CAM_OFS_PDIR, 8'h00);
    wr(`CAM_OFS_PCTL, 8'hff);
    rchk(`CAM_OFS_PCTL, 8'h03);
    chk({gp_pull_en, gp_reduced_drive}, 2'b11);
    // Random direction, latch and outside levels
    for (int t = 0; t < 8; t++) begin
      dv = $random(seed);
      ext_val <= 6'($random(seed));
      can_lvl <= 2'(t);
      wr(`CAM_OFS_PDIR, dv[15:8]);
      wr(`CAM_OFS_PDATA, dv[7:0]);
      // Pin outputs follow the registers one cycle later
      @(posedge mclk);
      #1 chk({gp_oe_n, gp_out}, {~dv[15:10], dv[7:2]});
      rd(`CAM_OFS_PDATA);
      chk(rd_val, {(dv[7:2] & dv[15:10]) | (ext_val & ~dv[15:10]), can_lvl});
    end
    // Inputs left open read the pull level
    ext_drv <= 1'b0;
    wr(`CAM_OFS_PDIR, 8'h00);
    rchk(`CAM_OFS_PDATA, {6'h3f, can_lvl});
    ext_drv <= 1'b1;
    wr(`CAM_OFS_PCTL, 8'h00);
    #1 chk({gp_pull_en, gp_reduced_drive}, 2'b00);
    // Mask writes only land during soft reset
    dv = $random(seed);
    wr(`CAM_OFS_MASK3, dv[7:0]);
    rchk(`CAM_OFS_MASK3, dv[7:0]);
    wr(`CAM_OFS_CTL0, 8'h00);
    wr(`CAM_OFS_MASK3, ~dv[7:0]);
    rchk(`CAM_OFS_MASK3, dv[7:0]);
    // Every filter organisation with random codes and masks
    for (int md = 0; md < 4; md++) begin
      wr(`CAM_OFS_CTL0, 8'h01);
      for (int i = 0; i < 8; i++) begin
        code[i] = 8'($random(seed));
        mask[i] = 8'($random(seed)) & 8'($random(seed));
        if (md < 2 && i % 2 == 1 && (md == 1 || i % 4 == 1)) mask[i] |= 8'h07;
        // Exact byte 0 in 8-bit mode, then fully open while it still holds
        if (i == 0 && md == 2) mask[0] = 8'h00;
        if (i == 0 && md == 3) mask[0] = 8'hff;
        wr(caddr(i), code[i]);
        wr(caddr(i) + 9'h004, mask[i]);
      end
      wr(`CAM_OFS_FCTL, 8'(md << 4));
      rx({code[3], code[2], code[1], code[0]}, 1'b1, 4'h0);
      wr(`CAM_OFS_CTL0, 8'h00);
      rd(`CAM_OFS_FCTL);
      chk(rd_val & 8'h30, 8'(md << 4));
      seen = 1'b0;
      hv = 3'h0;
      for (int t = 0; t < 16; t++) begin
        base = (t % 2) ? {code[7], code[6], code[5], code[4]}
          : {code[3], code[2], code[1], code[0]};
        id = base ^ ($random(seed) & $random(seed) & $random(seed));
        if (t < 2) id = base;
        ext = ((t / 2) % 2) == 1;
        e = exp_hit(2'(md), id, ext);
        rx(id, ext, e);
        rd(`CAM_OFS_FCTL);
        if (e[3]) begin
          hv = e[2:0];
          last_id = id[7:0];
          seen = 1'b1;
        end
        if (seen) chk(rd_val[2:0], hv);
        // Stored identifier changes only on an accepted message
        rd(`CAM_OFS_IDR);
        if (seen) chk(rd_val, last_id);
      end
    end
    give_verdict();
  end
endmodule // test_can_accept_mask_port_io
